// ===== design/uax_defines.vh
// Constants for the auxiliary-mode block of one serial channel
`ifndef UAX_DEFINES_VH
`define UAX_DEFINES_VH
`define UAX_ADDR_INT_EN 3'h1
`define UAX_ADDR_INT_STAT 3'h2
`define UAX_ADDR_ENH_FEAT 3'h2
`define UAX_ADDR_LINE_CTRL 3'h3
`define UAX_ADDR_MODEM_CTRL 3'h4
`define UAX_ADDR_MODEM_STAT 3'h6
`define UAX_ADDR_SPC 3'h7
`define UAX_LINE_CTRL_ENH 8'hbf
`define UAX_INT_EN_SLEEP 4
`define UAX_ENH_FEAT_SPECIAL 5
`define UAX_INT_STAT_SPECIAL 4
`define UAX_MODEM_CTRL_IRINV 2
`define UAX_MODEM_CTRL_LOOP 4
`define UAX_MODEM_CTRL_IR 6
`define UAX_IR_PULSE 8'h03
`define UAX_OVS 16
`define UAX_CHAR_BASE 10'h007
`define UAX_RST_BYTE 8'h00
`define UAX_INT_STAT_IDLE 8'h01
`define UAX_BAUD_DIV 16'h0001
`endif

// ===== design/uax_aux_modes.v
// Special character detect, infrared codec, auto sleep and loopback of one channel
// Functional notes
// - Compare characters only when special-enable set
// - Matched character still goes to FIFO
// - Match sets special flag in status
// - Compare only programmed word-length bits
// - Register bit 0 is first bit
// - Wait two characters before sending stop
// - Zero bit gives 3/16 high pulse
// - Infrared enable bit turns codec on
// - Infrared transmit and receive idle low
// - Light pulse decodes as logic one
// - Invert bit flips infrared receive input
// - Sleep needs idle, enabled, quiet, high lines
// - Oscillator output stops while asleep
// - Wake on start edge, write, modem change
// - Return to sleep once conditions hold
// - Modem status read clears change bits
// - Auto sleep until enable bit cleared
// - Loopback bit enables internal loopback
// - Transmit shifter feeds receive shifter
// - Loopback holds outputs, ignores modem inputs
// - No auto flow control in loopback
// - Special register at seven under 0xBF
`timescale 1ns/100ps
`include "uax_defines.vh"
module uax_aux_modes #(
  parameter BAUD_DIV = `UAX_BAUD_DIV
) (
  input wire clk,
  input wire rst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire tx_bit,
  input wire tx_active,
  input wire tx_hold_write,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire rx_trigger,
  input wire other_idle,
  input wire other_rx_high,
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire cd_n,
  input wire ri_n,
  input wire osc_in,
  output reg tx_pin,
  output reg rts_n,
  output reg dtr_n,
  output reg rx_serial,
  output reg fifo_wr,
  output reg [7:0] fifo_data,
  output reg send_stop_char,
  output reg sleep_req,
  output reg osc_out,
  output reg flow_allowed,
  output reg tick16
);

  // Sleep controller states
  localparam ST_AWAKE = 1'b0;
  localparam ST_ASLEEP = 1'b1;

  // Host-visible registers
  reg [7:0] interrupt_enable_reg_r;
  reg [7:0] enhanced_feature_reg_r;
  reg [7:0] line_control_reg_r;
  reg [7:0] modem_control_reg_r;
  reg [7:0] special_char_value_r;

  // Status flags
  reg special_r;
  reg [3:0] modem_delta_r;
  reg [3:0] modem_prev_r;

  // Tick divider and infrared encoder
  reg [15:0] div_r;
  reg [3:0] tick_r;
  reg [7:0] pulse_r;

  // Sleep, stop-character timer and read path
  reg rx_prev_r;
  reg sleep_state_r;
  reg sleep_state_nxt;
  reg wait_r;
  reg [9:0] wait_cnt_r;
  reg [7:0] mask;
  reg [9:0] char_ticks;
  reg [7:0] rdata_nxt;

  wire enh = (line_control_reg_r == `UAX_LINE_CTRL_ENH);
  wire loop = modem_control_reg_r[`UAX_MODEM_CTRL_LOOP];
  wire ir = modem_control_reg_r[`UAX_MODEM_CTRL_IR];
  wire ir_inv = modem_control_reg_r[`UAX_MODEM_CTRL_IRINV];
  wire tick = (div_r == 16'h0000);
  wire [15:0] div_nxt = tick ? (BAUD_DIV[15:0] - 16'h0001) : (div_r - 16'h0001);
  wire modem_stat_rd = rd && !enh && (addr == `UAX_ADDR_MODEM_STAT);
  wire int_stat_rd = rd && !enh && (addr == `UAX_ADDR_INT_STAT);
  wire any_irq = special_r || (|modem_delta_r);
  // Two characters of sixteen ticks per bit
  wire [9:0] wait_last = {char_ticks[4:0], 5'h00} - 10'h001;
  wire [3:0] modem_now;
  wire [3:0] modem_change;
  wire match;
  wire rx_eff;
  wire wake;
  wire can_sleep;

  assign modem_now = loop ?
    {modem_control_reg_r[3], modem_control_reg_r[2],
    modem_control_reg_r[0], modem_control_reg_r[1]} :
    {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
  assign modem_change = modem_now ^ modem_prev_r;

  assign match = enhanced_feature_reg_r[`UAX_ENH_FEAT_SPECIAL] && rx_char_valid &&
    (((rx_char ^ special_char_value_r) & mask) == 8'h00);

  assign rx_eff = ir ? (rx_pin ^ ir_inv) : rx_pin;

  assign wake = (rx_prev_r && !rx_pin) || tx_hold_write || (|modem_change);

  assign can_sleep = interrupt_enable_reg_r[`UAX_INT_EN_SLEEP] && !any_irq && other_idle &&
    (modem_delta_r == 4'h0) && rx_pin && other_rx_high && !tx_active;

  always @* begin
    case (line_control_reg_r[1:0])
      2'h0: begin
        mask = 8'h1f;
      end
      2'h1: begin
        mask = 8'h3f;
      end
      2'h2: begin
        mask = 8'h7f;
      end
      default: begin
        mask = 8'hff;
      end
    endcase
  end

  always @* begin
    char_ticks = `UAX_CHAR_BASE + {8'h00, line_control_reg_r[1:0]};
    if (line_control_reg_r[2]) begin
      char_ticks = char_ticks + 10'h001;
    end
    if (line_control_reg_r[3]) begin
      char_ticks = char_ticks + 10'h001;
    end
  end

  // Host register writes
  always @(posedge clk) begin
    if (rst) begin
      interrupt_enable_reg_r <= `UAX_RST_BYTE;
      enhanced_feature_reg_r <= `UAX_RST_BYTE;
      line_control_reg_r <= `UAX_RST_BYTE;
      modem_control_reg_r <= `UAX_RST_BYTE;
      special_char_value_r <= `UAX_RST_BYTE;
    end else if (wr) begin
      if (addr == `UAX_ADDR_LINE_CTRL) begin
        line_control_reg_r <= wdata;
      end else if (addr == `UAX_ADDR_MODEM_CTRL && !enh) begin
        modem_control_reg_r <= wdata;
      end else if (addr == `UAX_ADDR_INT_EN && !enh) begin
        interrupt_enable_reg_r <= wdata;
      end else if (addr == `UAX_ADDR_ENH_FEAT && enh) begin
        enhanced_feature_reg_r <= wdata;
      end else if (addr == `UAX_ADDR_SPC && enh) begin
        special_char_value_r <= wdata;
      end
    end
  end

  // Status flags; a set in the cycle of its clearing read wins
  always @(posedge clk) begin
    if (rst) begin
      special_r <= 1'b0;
      modem_delta_r <= 4'h0;
      modem_prev_r <= 4'h0;
    end else begin
      modem_prev_r <= modem_now;
      special_r <= match | (special_r & ~int_stat_rd);
      modem_delta_r <= modem_change | (modem_delta_r & {4{~modem_stat_rd}});
    end
  end

  // Read mux; unmapped or wrong-bank reads return zero
  always @* begin
    rdata_nxt = 8'h00;
    case (addr)
      `UAX_ADDR_INT_EN: begin
        if (!enh) begin
          rdata_nxt = interrupt_enable_reg_r;
        end
      end
      `UAX_ADDR_INT_STAT: begin
        if (enh) begin
          rdata_nxt = enhanced_feature_reg_r;
        end else if (any_irq) begin
          rdata_nxt[`UAX_INT_STAT_SPECIAL] = special_r;
        end else begin
          rdata_nxt = `UAX_INT_STAT_IDLE;
        end
      end
      `UAX_ADDR_LINE_CTRL: begin
        rdata_nxt = line_control_reg_r;
      end
      `UAX_ADDR_MODEM_CTRL: begin
        if (!enh) begin
          rdata_nxt = modem_control_reg_r;
        end
      end
      `UAX_ADDR_MODEM_STAT: begin
        if (!enh) begin
          rdata_nxt = {modem_now, modem_delta_r};
        end
      end
      `UAX_ADDR_SPC: begin
        if (enh) begin
          rdata_nxt = special_char_value_r;
        end
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Read data stands for exactly one cycle
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Sampling tick divider
  always @(posedge clk) begin
    if (rst) begin
      div_r <= 16'h0000;
      tick16 <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick16 <= tick;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      fifo_wr <= 1'b0;
      fifo_data <= 8'h00;
    end else begin
      fifo_wr <= rx_char_valid;
      fifo_data <= rx_char;
    end
  end

  // Three-tick pulse per zero
  // The slot count runs free, so tx_bit must change on slot starts
  always @(posedge clk) begin
    if (rst) begin
      tick_r <= 4'h0;
      pulse_r <= 8'h00;
    end else if (tick) begin
      tick_r <= tick_r + 4'h1;
      if (tick_r == 4'h0) begin
        pulse_r <= tx_bit ? 8'h00 : `UAX_IR_PULSE;
      end else if (pulse_r != 8'h00) begin
        pulse_r <= pulse_r - 8'h01;
      end
    end
  end

  // Line pins
  always @(posedge clk) begin
    if (rst) begin
      tx_pin <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      rx_serial <= 1'b1;
      flow_allowed <= 1'b1;
    end else begin
      // Auto flow control off in loopback
      flow_allowed <= ~loop;
      if (loop) begin
        tx_pin <= ~ir;
        rts_n <= 1'b1;
        dtr_n <= 1'b1;
        rx_serial <= tx_bit;
      end else begin
        if (ir) begin
          tx_pin <= tx_active && (pulse_r != 8'h00);
        end else begin
          tx_pin <= tx_bit;
        end
        rts_n <= ~modem_control_reg_r[1];
        dtr_n <= ~modem_control_reg_r[0];
        rx_serial <= rx_eff;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wait_r <= 1'b0;
      wait_cnt_r <= 10'h000;
      send_stop_char <= 1'b0;
    end else begin
      send_stop_char <= 1'b0;
      if (!rx_trigger) begin
        wait_r <= 1'b0;
        wait_cnt_r <= 10'h000;
      end else if (!wait_r && tick) begin
        if (wait_cnt_r == wait_last) begin
          wait_r <= 1'b1;
          send_stop_char <= 1'b1;
        end else begin
          wait_cnt_r <= wait_cnt_r + 10'h001;
        end
      end
    end
  end

  always @* begin
    sleep_state_nxt = sleep_state_r;
    case (sleep_state_r)
      ST_AWAKE: begin
        if (can_sleep && !wake) begin
          sleep_state_nxt = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (wake || !can_sleep) begin
          sleep_state_nxt = ST_AWAKE;
        end
      end
      default: begin
        sleep_state_nxt = ST_AWAKE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      sleep_state_r <= ST_AWAKE;
      rx_prev_r <= 1'b1;
      sleep_req <= 1'b0;
      osc_out <= 1'b0;
    end else begin
      sleep_state_r <= sleep_state_nxt;
      // Edge detector resets to the mark level, so reset makes no start edge
      rx_prev_r <= rx_pin;
      sleep_req <= (sleep_state_r == ST_ASLEEP);
      osc_out <= (sleep_state_r == ST_ASLEEP) ? 1'b0 : osc_in;
    end
  end
endmodule // uax_aux_modes

// ===== bench/uax_aux_modes_asserts.sv
// Port-level property checker for the auxiliary modes
`timescale 1ns/100ps
module uax_chk (
  input wire clk,
  input wire rst,
  input wire rx_char_valid,
  input wire fifo_wr,
  input wire tx_bit,
  input wire tx_hold_write,
  input wire rx_trigger,
  input wire other_idle,
  input wire rx_serial,
  input wire rts_n,
  input wire dtr_n,
  input wire send_stop_char,
  input wire sleep_req,
  input wire osc_out,
  input wire flow_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_fifo_pass: assert property (rx_char_valid |=> fifo_wr) else $error("char dropped");
  a_osc_stop: assert property (sleep_req && $past(sleep_req) |-> !osc_out) else $error("osc runs");
  a_wake_wr: assert property (tx_hold_write |-> ##[1:2] !sleep_req) else $error("no wake");
  a_sleep_cond: assert property ($rose(sleep_req) |-> $past(other_idle)) else $error("early");
  a_loop_pins: assert property (!flow_allowed |-> rts_n && dtr_n) else $error("pins moved");
  a_loop_route:
    assert property (!flow_allowed && !$past(flow_allowed) |-> rx_serial == $past(tx_bit))
      else $error("loop path broken");
  a_stop_wait: assert property ($rose(rx_trigger) |=> !send_stop_char [*8]) else $error("stop early");
  a_stop_held: assert property (send_stop_char |-> $past(rx_trigger, 8)) else $error("stop cause");
  c_wake: cover property (sleep_req ##1 !sleep_req);
  c_loop: cover property (!flow_allowed);
  c_stop: cover property (send_stop_char);
endmodule // uax_chk

// ===== bench/uax_remote.sv
// Remote transceiver model driving the receive line
`timescale 1ns/100ps
module uax_remote (
  input wire clk,
  input wire ir_mode,
  input wire flash,
  output logic rx_line
);
  initial rx_line = 1'b1;
  always @(posedge clk) rx_line <= ir_mode ? flash : 1'b1;
endmodule // uax_remote

// ===== bench/uax_aux_modes_tb.sv
// Self-checking bench for the auxiliary-mode block
`timescale 1ns/100ps
`include "uax_defines.vh"
module uax_aux_modes_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, tx_bit = 1, tx_active = 0, tx_hold_write = 0, ir = 0;
  logic rx_char_valid = 0, rx_trigger = 0, other_idle = 1, other_rx_high = 1, osc_in = 0;
  logic cts_n = 1, dsr_n = 1, cd_n = 1, ri_n = 1, flash = 0, rx_pin, tx_pin, rts_n, dtr_n;
  logic rx_serial, fifo_wr, send_stop_char, sleep_req, osc_out, flow_allowed, tick16;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, rx_char = 0, rdata, fifo_data;
  int error_cnt = 0, total_checks = 0;
  uax_aux_modes #(.BAUD_DIV(1)) dut_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx_bit,
    .tx_active, .tx_hold_write, .rx_char_valid, .rx_char, .rx_trigger, .other_idle, .other_rx_high,
    .rx_pin, .cts_n, .dsr_n, .cd_n, .ri_n, .osc_in, .tx_pin, .rts_n, .dtr_n, .rx_serial,
    .fifo_wr, .fifo_data, .send_stop_char, .sleep_req, .osc_out, .flow_allowed, .tick16);
  uax_remote far_u (.clk, .ir_mode(ir), .flash, .rx_line(rx_pin));
  initial forever #2 clk = ~clk;
  always @(posedge clk) osc_in <= ~osc_in;
  task chk(input string s, input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata & m, e);
  endtask
  task automatic wslp(input logic e);
    int n = 0;
    while (sleep_req !== e && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("sleep_req", sleep_req, e);
  endtask
  task t_sleep;
    other_idle <= 0;
    other_rx_high <= 0;
    wreg(`UAX_ADDR_INT_EN, 8'h10);
    repeat (4) @(posedge clk);
    #1 chk("sleep_held", sleep_req, 0);
    @(posedge clk);
    other_idle <= 1;
    other_rx_high <= 1;
    wslp(1);
    chk("osc_out", osc_out, 0);
    @(posedge clk);
    tx_hold_write <= 1;
    @(posedge clk);
    tx_hold_write <= 0;
    wslp(0);
    wslp(1);
    @(posedge clk);
    cts_n <= 0;
    wslp(0);
    rchk(`UAX_ADDR_MODEM_STAT, 8'h11, 8'hff);
    rchk(`UAX_ADDR_MODEM_STAT, 8'h10, 8'hff);
    wslp(1);
    wreg(`UAX_ADDR_INT_EN, 8'h00);
    wslp(0);
  endtask
  task rxc(input logic [7:0] c);
    @(posedge clk);
    rx_char_valid <= 1;
    rx_char <= c;
    @(posedge clk);
    rx_char_valid <= 0;
    #1 chk("fifo_data", fifo_data, c);
  endtask
  task t_spc;
    wreg(`UAX_ADDR_LINE_CTRL, `UAX_LINE_CTRL_ENH);
    wreg(`UAX_ADDR_ENH_FEAT, 8'h20);
    wreg(`UAX_ADDR_SPC, 8'h1d);
    wreg(`UAX_ADDR_LINE_CTRL, 8'h00);
    // Five-bit words: the upper three bits must not matter
    rxc(8'hfd);
    rchk(`UAX_ADDR_INT_STAT, 8'h10, 8'hff);
    rchk(`UAX_ADDR_INT_STAT, `UAX_INT_STAT_IDLE, 8'hff);
    rxc(8'h1c);
    rchk(`UAX_ADDR_INT_STAT, `UAX_INT_STAT_IDLE, 8'hff);
  endtask
  task automatic t_ir;
    int n;
    wreg(`UAX_ADDR_MODEM_CTRL, 8'h40);
    #1 chk("tick16", tick16, 1);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      tx_active <= 1;
      tx_bit <= b[0];
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        #1 n += tx_pin;
      end
      chk("ir_high", n[7:0], b ? 8'h00 : 8'h03);
    end
    @(posedge clk);
    tx_active <= 0;
    ir <= 1;
    flash <= 1;
    repeat (4) @(posedge clk);
    #1 chk("ir_idle", tx_pin, 0);
    chk("ir_rx", rx_serial, 1);
    wreg(`UAX_ADDR_MODEM_CTRL, 8'h44);
    repeat (3) @(posedge clk);
    #1 chk("ir_inv", rx_serial, 0);
    @(posedge clk);
    ir <= 0;
    flash <= 0;
  endtask
  task t_loop;
    wreg(`UAX_ADDR_MODEM_CTRL, 8'h13);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      tx_bit <= i[0];
      cts_n <= i[1];
    end
    repeat (2) @(posedge clk);
    #1 chk("rx_serial", rx_serial, 0);
    chk("rts_dtr", {rts_n, dtr_n}, 2'b11);
    chk("tx_held", tx_pin, 1);
    chk("flow_allowed", flow_allowed, 0);
    rchk(`UAX_ADDR_MODEM_STAT, 8'h30, 8'hf0);
    wreg(`UAX_ADDR_MODEM_CTRL, 8'h00);
  endtask
  task automatic t_stop;
    int n = 0;
    @(posedge clk);
    rx_trigger <= 1;
    while (send_stop_char !== 1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("stop_wait", (n == 2 * 7 * `UAX_OVS), 1);
    @(posedge clk);
    rx_trigger <= 0;
  endtask
  task print_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_sleep;
    t_spc;
    t_ir;
    t_loop;
    t_stop;
    print_verdict;
  end
  initial begin
    #200000;
    error_cnt++;
    print_verdict;
  end
endmodule // uax_aux_modes_tb
bind uax_aux_modes uax_chk chk_u (.clk, .rst, .rx_char_valid, .fifo_wr, .tx_bit, .tx_hold_write,
  .rx_trigger, .other_idle, .rx_serial, .rts_n, .dtr_n, .send_stop_char, .sleep_req, .osc_out,
  .flow_allowed);
